/* File: core/gdfs_top.sv */
// Fault supervisor for a two-channel high-side gate driver.
// Contract
// - Supply overvoltage sets flags, selectable restart delay.
// - Supply undervoltage sets flags, selectable restart delay.
// - Refuse channel activation while restart delay runs.
// - Enable toggle, power cycle, command clear latches.
// - Blank timer masks detections after turn-on.
// - Per-channel blank time select, default 10 us.
// - Gate charge current ends within blank time.
// - Fault accepted only after persisting past filter.
// - Per-channel filter select, default 1 us.
// - Drain-source checked only on switched-on channels.
// - Trip, policy 0: flags set, channel off.
// - Trip, policy 1: flags set, channel stays on.
// - Per-channel 3-bit threshold select, default 200 mV.
// - Same code sets negative trip level too.
// - Policy 0: clearing trip flag re-enables channel.
// - Re-enabled channel is blanked, filtered, tripped again.
// - Stay-on policy resets to 0.
// - Any fault sets fault flag, interrupt, channel off; a policy 1 trip sets the flags but leaves the channel on.
// - Supply faults self-recover after restart delay.
`timescale 1ns/1ps
`include "gdfs_consts.svh"
module gdfs_top #(
  // Restart delays in cycles, shortened for simulation if needed.
  parameter int OV_RST2_CYC = `GDFS_OV_RST2_CYC,
  parameter int OV_RST3_CYC = `GDFS_OV_RST3_CYC,
  parameter int UV_RST0_CYC = `GDFS_UV_RST0_CYC,
  parameter int UV_RST1_CYC = `GDFS_UV_RST1_CYC,
  parameter int UV_RST2_CYC = `GDFS_UV_RST2_CYC,
  parameter int UV_RST3_CYC = `GDFS_UV_RST3_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Analog comparator results and enable pin, asynchronous.
  input wire logic supply_ov_cmp,
  input wire logic supply_uv_cmp,
  input wire logic [1:0] ds_pos_cmp,
  input wire logic [1:0] ds_neg_cmp,
  input wire logic enable_pin,
  // Microcontroller commands, one-cycle pulses.
  input wire logic [1:0] on_req,
  input wire logic [1:0] off_req,
  input wire logic [1:0] trip_clear,
  input wire logic clear_cmd,
  input wire logic logic_uv_clear,
  // Configuration, taken when cfg_load pulses.
  input wire logic cfg_load,
  input wire logic [1:0] cfg_ov_restart_delay_sel,
  input wire logic [1:0] cfg_uv_restart_delay_sel,
  input wire logic [3:0] cfg_blank_time_sel,
  input wire logic [3:0] cfg_filter_time_sel,
  input wire logic [5:0] cfg_drain_source_threshold_sel,
  input wire logic [1:0] cfg_stay_on_policy,
  // Status.
  output logic fault_flag,
  output logic interrupt,
  output logic supply_overvoltage_flag,
  output logic supply_undervoltage_flag,
  output logic logic_supply_undervoltage_flag,
  output logic restart_busy,
  output logic [1:0] drain_source_trip_flag,
  output logic [1:0] channel_on_command,
  // Gate drive and comparator reference code.
  output logic [1:0] gate_drive_on,
  output logic [1:0] gate_charge_on,
  output logic [5:0] ds_threshold_code
);
  localparam int NSYNC = 7; // Synchronised inputs.
  localparam int EN = 6; // Enable bit position.

  logic [NSYNC-1:0] sync_a_r; // First synchroniser stage.
  logic [NSYNC-1:0] sync_b_r; // Second synchroniser stage.
  logic en_d_r; // Delayed enable for toggle detection.
  logic en_toggle; // Enable changed level.
  logic clear_any; // Latched-fault clear event.

  logic [1:0] ov_sel_r; // Overvoltage restart select.
  logic [1:0] uv_sel_r; // Undervoltage restart select.
  logic [3:0] blk_sel_r; // Blank select, two bits per channel.
  logic [3:0] flt_sel_r; // Filter select, two bits per channel.
  logic [5:0] thr_sel_r; // Threshold select, three bits per channel.
  logic [1:0] policy_r; // Stay-on policy per channel.

  gdfs_pkg::gdfs_sup_state_t sup_st_r [2]; // Supply state, 0 over, 1 under.
  gdfs_pkg::gdfs_sup_state_t sup_st_nxt [2];
  logic [21:0] sup_cnt_r [2]; // Restart counters.
  logic [21:0] sup_cnt_nxt [2];
  logic [21:0] sup_dly [2]; // Selected restart delays.
  logic sup_block_r; // Supply fault or restart in progress.
  logic sup_block_nxt;
  logic [1:0] sup_flag_r; // Registered supply fault flags, 0 over, 1 under.

  logic fault_r; // General fault flag.
  logic fault_nxt;
  logic irq_r; // Interrupt output.
  logic logic_supply_undervoltage_flag_r; // Logic supply undervoltage flag.
  logic [1:0] trip_flag_r; // Drain-source trip flags.
  logic [1:0] trip_flag_nxt;
  logic [1:0] on_cmd_r; // Channel on-command bits.
  logic [1:0] on_cmd_nxt;
  logic [1:0] drive_r; // Gate drive enables.
  logic [1:0] reon; // Automatic re-enable after flag clear.
  logic [1:0] ds_trip; // Qualified trip pulses.
  logic [1:0] charge; // Charge current per channel.
  logic [11:0] blank_cyc [2]; // Blank time in cycles.
  logic [7:0] filt_cyc [2]; // Filter time in cycles.

  // Two-stage synchronisers on every asynchronous input.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a_r <= '0;
      sync_b_r <= '0;
      en_d_r <= 1'b0;
    end else begin
      sync_a_r <= {enable_pin, ds_neg_cmp, ds_pos_cmp, supply_uv_cmp, supply_ov_cmp};
      sync_b_r <= sync_a_r;
      en_d_r <= sync_b_r[EN];
    end
  end

  assign en_toggle = sync_b_r[EN] ^ en_d_r;
  assign clear_any = clear_cmd | en_toggle;

  // Configuration registers with their documented reset values.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_sel_r <= `GDFS_OV_SEL_RST;
      uv_sel_r <= `GDFS_UV_SEL_RST;
      blk_sel_r <= {2{`GDFS_BLK_SEL_RST}};
      flt_sel_r <= {2{`GDFS_FLT_SEL_RST}};
      thr_sel_r <= {2{`GDFS_THR_SEL_RST}};
      policy_r <= {2{`GDFS_POLICY_RST}};
    end else if (cfg_load) begin
      ov_sel_r <= cfg_ov_restart_delay_sel;
      uv_sel_r <= cfg_uv_restart_delay_sel;
      blk_sel_r <= cfg_blank_time_sel;
      flt_sel_r <= cfg_filter_time_sel;
      thr_sel_r <= cfg_drain_source_threshold_sel;
      policy_r <= cfg_stay_on_policy;
    end
  end

  // Decode the selects into cycle counts.
  always_comb begin
    case (ov_sel_r)
      2'h0: sup_dly[0] = 22'(`GDFS_OV_RST0_CYC);
      2'h1: sup_dly[0] = 22'(`GDFS_OV_RST1_CYC);
      2'h2: sup_dly[0] = 22'(OV_RST2_CYC);
      default: sup_dly[0] = 22'(OV_RST3_CYC);
    endcase
    case (uv_sel_r)
      2'h0: sup_dly[1] = 22'(UV_RST0_CYC);
      2'h1: sup_dly[1] = 22'(UV_RST1_CYC);
      2'h2: sup_dly[1] = 22'(UV_RST2_CYC);
      default: sup_dly[1] = 22'(UV_RST3_CYC);
    endcase
    for (int i = 0; i < 2; i++) begin
      case (blk_sel_r[2*i +: 2])
        2'h0: blank_cyc[i] = 12'(`GDFS_BLK0_CYC);
        2'h1: blank_cyc[i] = 12'(`GDFS_BLK1_CYC);
        2'h2: blank_cyc[i] = 12'(`GDFS_BLK2_CYC);
        default: blank_cyc[i] = 12'(`GDFS_BLK3_CYC);
      endcase
      case (flt_sel_r[2*i +: 2])
        2'h0: filt_cyc[i] = 8'(`GDFS_FLT0_CYC);
        2'h1: filt_cyc[i] = 8'(`GDFS_FLT1_CYC);
        2'h2: filt_cyc[i] = 8'(`GDFS_FLT2_CYC);
        default: filt_cyc[i] = 8'(`GDFS_FLT3_CYC);
      endcase
    end
  end

  // Supply fault and auto-restart sequencing; a fault during the wait restarts it.
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      sup_st_nxt[k] = sup_st_r[k];
      sup_cnt_nxt[k] = sup_cnt_r[k];
      case (sup_st_r[k])
        gdfs_pkg::SUP_OK: begin
          if (sync_b_r[k]) begin
            sup_st_nxt[k] = gdfs_pkg::SUP_FAULT;
          end
        end
        gdfs_pkg::SUP_FAULT: begin
          if (!sync_b_r[k]) begin
            sup_st_nxt[k] = gdfs_pkg::SUP_WAIT;
            sup_cnt_nxt[k] = 22'h000001;
          end
        end
        gdfs_pkg::SUP_WAIT: begin
          if (sync_b_r[k]) begin
            sup_st_nxt[k] = gdfs_pkg::SUP_FAULT;
          end else if (sup_cnt_r[k] >= sup_dly[k]) begin
            sup_st_nxt[k] = gdfs_pkg::SUP_OK;
          end else begin
            sup_cnt_nxt[k] = sup_cnt_r[k] + 22'h000001;
          end
        end
        default: begin
          sup_st_nxt[k] = gdfs_pkg::SUP_OK;
        end
      endcase
    end
    sup_block_nxt = (sup_st_nxt[0] != gdfs_pkg::SUP_OK) || (sup_st_nxt[1] != gdfs_pkg::SUP_OK);
  end

  // Supply state registers.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sup_st_r <= '{gdfs_pkg::SUP_OK, gdfs_pkg::SUP_OK};
      sup_cnt_r <= '{22'h000000, 22'h000000};
      sup_block_r <= 1'b0;
      sup_flag_r <= 2'h0;
    end else begin
      sup_st_r <= sup_st_nxt;
      sup_cnt_r <= sup_cnt_nxt;
      sup_block_r <= sup_block_nxt;
      sup_flag_r <= {sup_st_nxt[1] != gdfs_pkg::SUP_OK, sup_st_nxt[0] != gdfs_pkg::SUP_OK};
    end
  end

  // Trip flags, on-commands and the general fault flag; a set beats a clear, except a policy 0 trip switch-off beats an on-request.
  always_comb begin
    fault_nxt = (fault_r & ~clear_any) | (|ds_trip) |
      (sup_st_nxt[0] == gdfs_pkg::SUP_FAULT) | (sup_st_nxt[1] == gdfs_pkg::SUP_FAULT);
    for (int i = 0; i < 2; i++) begin
      reon[i] = trip_flag_r[i] & (clear_any | trip_clear[i]) & ~policy_r[i] & ~ds_trip[i];
      trip_flag_nxt[i] = (trip_flag_r[i] & ~(clear_any | trip_clear[i])) | ds_trip[i];
      on_cmd_nxt[i] = on_cmd_r[i];
      if (off_req[i]) begin
        on_cmd_nxt[i] = 1'b0;
      end
      if (on_req[i] && !sup_block_r) begin
        on_cmd_nxt[i] = 1'b1;
      end
      if (reon[i]) begin
        on_cmd_nxt[i] = 1'b1;
      end
      if (ds_trip[i] && !policy_r[i]) begin
        on_cmd_nxt[i] = 1'b0;
      end
    end
  end

  // Flag and drive registers; supply faults gate the drive but keep the command.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
      irq_r <= 1'b0;
      trip_flag_r <= 2'h0;
      on_cmd_r <= 2'h0;
      drive_r <= 2'h0;
    end else begin
      fault_r <= fault_nxt;
      irq_r <= fault_nxt;
      trip_flag_r <= trip_flag_nxt;
      on_cmd_r <= on_cmd_nxt;
      drive_r <= on_cmd_nxt & {2{~sup_block_nxt}};
    end
  end

  // Logic supply undervoltage flag is raised by the power-up reset itself.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      logic_supply_undervoltage_flag_r <= 1'b1;
    end else if (logic_uv_clear) begin
      logic_supply_undervoltage_flag_r <= 1'b0;
    end
  end

  // One qualifier per channel; both comparator polarities share the threshold code.
  for (genvar g = 0; g < 2; g++) begin : g_chan
    gdfs_chan u_chan (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .drive_on(drive_r[g]),
      .ds_cond(sync_b_r[2+g] | sync_b_r[4+g]),
      .blank_cyc(blank_cyc[g]),
      .filt_cyc(filt_cyc[g]),
      .charge_on(charge[g]),
      .ds_trip(ds_trip[g])
    );
  end

  assign fault_flag = fault_r;
  assign interrupt = irq_r;
  assign supply_overvoltage_flag = sup_flag_r[0];
  assign supply_undervoltage_flag = sup_flag_r[1];
  assign logic_supply_undervoltage_flag = logic_supply_undervoltage_flag_r;
  assign restart_busy = sup_block_r;
  assign drain_source_trip_flag = trip_flag_r;
  assign channel_on_command = on_cmd_r;
  assign gate_drive_on = drive_r;
  assign gate_charge_on = charge;
  assign ds_threshold_code = thr_sel_r;

  ov_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sync_b_r[0] |=> supply_overvoltage_flag && fault_r && irq_r)
    else $error("Overvoltage flags not set.");
  uv_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sync_b_r[1] |=> supply_undervoltage_flag && fault_r)
    else $error("Undervoltage flags not set.");
  restart_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sup_block_r |-> drive_r == 2'h0)
    else $error("Channel driven during restart delay.");
  refuse_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sup_block_r && on_req[0] && !on_cmd_r[0] && !reon[0] |=> !on_cmd_r[0])
    else $error("Activation accepted during restart delay.");
  trip_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ds_trip[0] && !policy_r[0] |=> !on_cmd_r[0] && trip_flag_r[0] && fault_r)
    else $error("Trip did not switch channel off.");
  stay_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ds_trip[1] && policy_r[1] && on_cmd_r[1] && !off_req[1] |=> on_cmd_r[1] && trip_flag_r[1])
    else $error("Stay-on channel was switched off.");
  reon_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    trip_flag_r[0] && trip_clear[0] && !policy_r[0] && !ds_trip[0] && !off_req[0] |=> on_cmd_r[0] && !trip_flag_r[0])
    else $error("Channel not re-enabled after flag clear.");
  clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clear_cmd && ds_trip == 2'h0 |=> trip_flag_r == 2'h0 && (logic_supply_undervoltage_flag_r == $past(logic_supply_undervoltage_flag_r) || $past(logic_uv_clear)))
    else $error("Clear command misbehaved.");
  restart_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sup_st_r[0] == gdfs_pkg::SUP_WAIT && !sync_b_r[0] && sup_cnt_r[0] >= sup_dly[0] |=> !supply_overvoltage_flag)
    else $error("Overvoltage restart did not end on time.");
  restart_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(sup_block_r));
  reon_c: cover property (@(posedge ref_clk) disable iff (!rst_n) reon[0] ##[1:1000] ds_trip[0]);
  stay_c: cover property (@(posedge ref_clk) disable iff (!rst_n) ds_trip[1] && policy_r[1]);
endmodule : gdfs_top

/* File: core/gdfs_consts.svh */
// Timing counts and reset values for the gate driver fault supervisor.
`ifndef GDFS_CONSTS_SVH
`define GDFS_CONSTS_SVH
// Functional clock rate.
`define GDFS_CLK_MHZ 40
// Supply overvoltage restart delays in microseconds, and their counts.
`define GDFS_OV_RST0_US 10
`define GDFS_OV_RST1_US 50
`define GDFS_OV_RST2_US 200
`define GDFS_OV_RST3_US 1000
`define GDFS_OV_RST0_CYC (`GDFS_OV_RST0_US * `GDFS_CLK_MHZ)
`define GDFS_OV_RST1_CYC (`GDFS_OV_RST1_US * `GDFS_CLK_MHZ)
`define GDFS_OV_RST2_CYC (`GDFS_OV_RST2_US * `GDFS_CLK_MHZ)
`define GDFS_OV_RST3_CYC (`GDFS_OV_RST3_US * `GDFS_CLK_MHZ)
// Supply undervoltage restart delays in milliseconds, and their counts.
`define GDFS_UV_RST0_MS 1
`define GDFS_UV_RST1_MS 5
`define GDFS_UV_RST2_MS 20
`define GDFS_UV_RST3_MS 50
`define GDFS_UV_RST0_CYC (`GDFS_UV_RST0_MS * 1000 * `GDFS_CLK_MHZ)
`define GDFS_UV_RST1_CYC (`GDFS_UV_RST1_MS * 1000 * `GDFS_CLK_MHZ)
`define GDFS_UV_RST2_CYC (`GDFS_UV_RST2_MS * 1000 * `GDFS_CLK_MHZ)
`define GDFS_UV_RST3_CYC (`GDFS_UV_RST3_MS * 1000 * `GDFS_CLK_MHZ)
// Blank times in microseconds, and their counts.
`define GDFS_BLK0_US 10
`define GDFS_BLK1_US 20
`define GDFS_BLK2_US 50
`define GDFS_BLK3_US 100
`define GDFS_BLK0_CYC (`GDFS_BLK0_US * `GDFS_CLK_MHZ)
`define GDFS_BLK1_CYC (`GDFS_BLK1_US * `GDFS_CLK_MHZ)
`define GDFS_BLK2_CYC (`GDFS_BLK2_US * `GDFS_CLK_MHZ)
`define GDFS_BLK3_CYC (`GDFS_BLK3_US * `GDFS_CLK_MHZ)
// Filter times in nanoseconds, and their counts.
`define GDFS_FLT0_NS 500
`define GDFS_FLT1_NS 1000
`define GDFS_FLT2_NS 2000
`define GDFS_FLT3_NS 5000
`define GDFS_FLT0_CYC (`GDFS_FLT0_NS * `GDFS_CLK_MHZ / 1000)
`define GDFS_FLT1_CYC (`GDFS_FLT1_NS * `GDFS_CLK_MHZ / 1000)
`define GDFS_FLT2_CYC (`GDFS_FLT2_NS * `GDFS_CLK_MHZ / 1000)
`define GDFS_FLT3_CYC (`GDFS_FLT3_NS * `GDFS_CLK_MHZ / 1000)
// Configuration reset values.
`define GDFS_OV_SEL_RST 2'h0
`define GDFS_UV_SEL_RST 2'h0
`define GDFS_BLK_SEL_RST 2'h0
`define GDFS_FLT_SEL_RST 2'h1
`define GDFS_THR_SEL_RST 3'h2
`define GDFS_POLICY_RST 1'h0
`endif

/* File: core/gdfs_pkg.sv */
// Types shared by the gate driver fault supervisor.
package gdfs_pkg;
  // Per-channel monitor state.
  typedef enum logic [1:0] {CH_OFF, CH_BLANK, CH_MON} gdfs_ch_state_t;
  // Supply auto-restart state.
  typedef enum logic [1:0] {SUP_OK, SUP_FAULT, SUP_WAIT} gdfs_sup_state_t;
endpackage : gdfs_pkg

/* File: core/gdfs_chan.sv */
// Per-channel blank, filter and drain-source trip qualifier.
`timescale 1ns/1ps
module gdfs_chan (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Channel drive state and synchronised comparator condition.
  input wire logic drive_on,
  input wire logic ds_cond,
  // Selected times in cycles.
  input wire logic [11:0] blank_cyc,
  input wire logic [7:0] filt_cyc,
  // Results.
  output logic charge_on,
  output logic ds_trip
);
  gdfs_pkg::gdfs_ch_state_t st_r; // Monitor state.
  logic [11:0] blk_cnt_r; // Blank timer.
  logic [7:0] flt_cnt_r; // Filter timer.
  logic held_r; // Trip already reported for this episode.
  logic charge_r; // Gate charge current enable.
  logic trip_r; // One-cycle trip pulse.

  // Blank timer starts at each turn-on; monitoring only while the channel is driven.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= gdfs_pkg::CH_OFF;
      blk_cnt_r <= 12'h000;
    end else if (!drive_on) begin
      st_r <= gdfs_pkg::CH_OFF;
      blk_cnt_r <= 12'h000;
    end else begin
      case (st_r)
        gdfs_pkg::CH_OFF: begin
          st_r <= gdfs_pkg::CH_BLANK;
          blk_cnt_r <= 12'h001;
        end
        gdfs_pkg::CH_BLANK: begin
          if (blk_cnt_r >= blank_cyc) begin
            st_r <= gdfs_pkg::CH_MON;
          end else begin
            blk_cnt_r <= blk_cnt_r + 12'h001;
          end
        end
        gdfs_pkg::CH_MON: begin
          st_r <= gdfs_pkg::CH_MON;
        end
        default: begin
          st_r <= gdfs_pkg::CH_OFF;
        end
      endcase
    end
  end

  // Charge current only flows inside the blank window.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_r <= 1'b0;
    end else begin
      charge_r <= drive_on && (st_r == gdfs_pkg::CH_OFF || (st_r == gdfs_pkg::CH_BLANK && blk_cnt_r < blank_cyc));
    end
  end

  // Filter counter restarts whenever the condition drops out.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flt_cnt_r <= 8'h00;
      held_r <= 1'b0;
      trip_r <= 1'b0;
    end else if (st_r != gdfs_pkg::CH_MON || !drive_on || !ds_cond) begin
      flt_cnt_r <= 8'h00;
      held_r <= 1'b0;
      trip_r <= 1'b0;
    end else if (flt_cnt_r < filt_cyc) begin
      flt_cnt_r <= flt_cnt_r + 8'h01;
      trip_r <= 1'b0;
    end else begin
      // Condition held beyond the filter time: report once per episode.
      trip_r <= !held_r;
      held_r <= 1'b1;
    end
  end

  assign charge_on = charge_r;
  assign ds_trip = trip_r;

  blank_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_r != gdfs_pkg::CH_MON) |=> !trip_r)
    else $error("Trip reported during blanking.");
  charge_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_r == gdfs_pkg::CH_MON) |=> !charge_r)
    else $error("Charge current still on after blanking.");
  filt_restart_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ds_cond |=> (flt_cnt_r == 8'h00))
    else $error("Filter count not restarted.");
  filt_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(trip_r) |-> $past(flt_cnt_r) == filt_cyc && $past(ds_cond))
    else $error("Trip before filter time elapsed.");
  trip_on_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    trip_r |-> $past(drive_on))
    else $error("Trip on a channel that was off.");
  trip_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(trip_r));
endmodule : gdfs_chan

/* File: dv/gdfs_cmp_model.sv */
// Drain-source comparator model that turns threshold codes and voltages into trip levels.
`timescale 1ns/1ps
module gdfs_cmp_model (
  // Threshold codes driven by the supervisor.
  input wire logic [5:0] ds_threshold_code,
  // Drain-source voltages of both channels in millivolts.
  input wire logic signed [15:0] vds0_mv,
  input wire logic signed [15:0] vds1_mv,
  // Comparator results per channel.
  output logic [1:0] ds_pos_cmp,
  output logic [1:0] ds_neg_cmp
);
  // Trip magnitude in millivolts for each threshold code.
  logic signed [15:0] lvl [8];
  assign lvl = '{16'sh0064, 16'sh0096, 16'sh00C8, 16'sh00FA, 16'sh012C, 16'sh0190, 16'sh01F4, 16'sh0258};
  // The positive level trips above it, the mirrored level below its negative.
  always_comb begin
    ds_pos_cmp[0] = vds0_mv > lvl[ds_threshold_code[2:0]];
    ds_pos_cmp[1] = vds1_mv > lvl[ds_threshold_code[5:3]];
    ds_neg_cmp[0] = vds0_mv < -lvl[ds_threshold_code[2:0]];
    ds_neg_cmp[1] = vds1_mv < -lvl[ds_threshold_code[5:3]];
  end
endmodule : gdfs_cmp_model

/* File: dv/testbench.sv */
// Self-checking bench for the gate driver fault supervisor.
`timescale 1ns/1ps
`include "gdfs_consts.svh"
module testbench;
  // Stimulus, given a value at time zero; pos and neg are driven by the comparator model, thr_code by the supervisor.
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ov = 1'b0, uv = 1'b0, en = 1'b0, cfg_load = 1'b0, clear_cmd = 1'b0, luv_clr = 1'b0;
  logic [1:0] on_req = 2'h0, off_req = 2'h0, trip_clear = 2'h0, pol = 2'h0, pos, neg;
  logic [5:0] thr = 6'h12, thr_code;
  logic [1:0] ovs = 2'h0, uvs = 2'h0;
  logic [3:0] blk = 4'h0, flt = 4'h5;
  logic signed [15:0] vds0 = 16'sh0, vds1 = 16'sh0;
  // Observed outputs.
  logic ff, irq, ovf, uvf, luvf, rb;
  logic [1:0] trip, cmd, drv, chg;
  // Expected trip magnitudes, kept apart from the comparator model.
  logic signed [15:0] mv [8] = '{16'sh0064, 16'sh0096, 16'sh00C8, 16'sh00FA, 16'sh012C, 16'sh0190, 16'sh01F4, 16'sh0258};
  int failures = 0, num_checks = 0, seed = 32'h1e54a583;
  logic [2:0] c;
  logic [1:0] bs, fs;
  logic e;
  // Undervoltage restart shortened so the run stays brief.
  gdfs_top #(.UV_RST1_CYC(60)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .supply_ov_cmp(ov), .supply_uv_cmp(uv),
    .ds_pos_cmp(pos), .ds_neg_cmp(neg), .enable_pin(en), .on_req(on_req), .off_req(off_req),
    .trip_clear(trip_clear), .clear_cmd(clear_cmd), .logic_uv_clear(luv_clr), .cfg_load(cfg_load),
    .cfg_ov_restart_delay_sel(ovs), .cfg_uv_restart_delay_sel(uvs), .cfg_blank_time_sel(blk),
    .cfg_filter_time_sel(flt), .cfg_drain_source_threshold_sel(thr), .cfg_stay_on_policy(pol),
    .fault_flag(ff), .interrupt(irq), .supply_overvoltage_flag(ovf), .supply_undervoltage_flag(uvf),
    .logic_supply_undervoltage_flag(luvf), .restart_busy(rb), .drain_source_trip_flag(trip),
    .channel_on_command(cmd), .gate_drive_on(drv), .gate_charge_on(chg), .ds_threshold_code(thr_code));
  // Far-side comparators answer the threshold code.
  gdfs_cmp_model i_cmp (.ds_threshold_code(thr_code), .vds0_mv(vds0), .vds1_mv(vds1), .ds_pos_cmp(pos),
    .ds_neg_cmp(neg));
  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // Compares one observed value with its expectation.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Blank plus filter time in cycles for one channel's select codes.
  function automatic int win(input logic [1:0] b, input logic [1:0] f);
    int bt [4];
    int ft [4];
    bt = '{`GDFS_BLK0_CYC, `GDFS_BLK1_CYC, `GDFS_BLK2_CYC, `GDFS_BLK3_CYC};
    ft = '{`GDFS_FLT0_CYC, `GDFS_FLT1_CYC, `GDFS_FLT2_CYC, `GDFS_FLT3_CYC};
    return bt[b] + ft[f];
  endfunction : win
  // Waits n edges, then moves off the edge by the fixed drive delay.
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : cyc
  // Waits, under a bound, for the restart delay to end.
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (rb !== 1'b0 && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      failures++;
      $display("Error restart_busy expected 0 seen %h", rb);
      end_sim();
    end
  endtask : wait_idle
  // Loads threshold codes and policy bits through one load pulse.
  task automatic cfg(input logic [5:0] t, input logic [1:0] p);
    thr = t;
    pol = p;
    cfg_load = 1'b1;
    cyc(1);
    cfg_load = 1'b0;
  endtask : cfg
  // Main sequence.
  initial begin
    repeat (8) @(posedge ref_clk);
    #2;
    rst_n = 1'b1;
    cyc(1);
    chk("threshold code", 16'h0012, thr_code);
    chk("logic uv flag", 16'h0001, luvf);
    chk("fault flag", 16'h0000, ff);
    $display("Test reset done");
    // Turn-on opens the charge window for one blank time.
    on_req = 2'h1;
    cyc(1);
    on_req = 2'h0;
    cyc(2);
    chk("on command", 16'h0001, cmd[0]);
    chk("charge on", 16'h0001, chg[0]);
    cyc(402);
    chk("charge after blank", 16'h0000, chg[0]);
    // A burst shorter than the filter time, a gap, then a burst held past the filter time.
    vds0 = 16'sh012C;
    cyc(30);
    vds0 = 16'sh0;
    cyc(5);
    vds0 = 16'sh012C;
    cyc(30);
    chk("trip after glitches", 16'h0000, trip[0]);
    cyc(30);
    chk("trip flag", 16'h0001, trip[0]);
    chk("on command cut", 16'h0000, cmd[0]);
    chk("interrupt", 16'h0001, irq);
    trip_clear = 2'h1;
    cyc(1);
    trip_clear = 2'h0;
    cyc(2);
    chk("re-enabled", 16'h0001, cmd[0]);
    chk("re-blanked", 16'h0001, chg[0]);
    cyc(500);
    chk("second trip", 16'h0002, {trip[0], cmd[0]});
    vds0 = 16'sh0;
    clear_cmd = 1'b1;
    cyc(1);
    clear_cmd = 1'b0;
    off_req = 2'h1;
    cyc(1);
    off_req = 2'h0;
    chk("fault cleared", 16'h0000, ff);
    $display("Test policy off done");
    // Stay-on channel with a negative excursion past the lowest level.
    cfg(6'h02, 2'h2);
    vds1 = -16'sh0096;
    on_req = 2'h2;
    cyc(1);
    on_req = 2'h0;
    cyc(500);
    chk("stay-on trip", 16'h0007, {trip[1], cmd[1], drv[1]});
    vds1 = 16'sh0;
    en = 1'b1;
    cyc(6);
    chk("enable clear", 16'h0000, {ff, trip[1]});
    off_req = 2'h2;
    cyc(1);
    off_req = 2'h0;
    $display("Test policy on done");
    // Random codes, times and voltages, boundary values first.
    for (int i = 0; i < 6; i++) begin
      c = 3'($random(seed));
      bs = 2'($random(seed));
      fs = 2'($random(seed));
      blk = {2'h0, bs};
      flt = {2'h1, fs};
      vds0 = (i == 0) ? mv[c] : (i == 1) ? -mv[c] - 16'sh1 : 16'($random(seed) % 700);
      e = (vds0 > mv[c]) || (vds0 < -mv[c]);
      cfg({3'h2, c}, 2'h0);
      cyc(100);
      chk("off channel trip", 16'h0000, trip[0]);
      chk("code out", {13'h0, c}, thr_code[2:0]);
      on_req = 2'h1;
      cyc(1);
      on_req = 2'h0;
      cyc(win(bs, fs) + 2);
      chk("window end", 16'h0000, {trip[0], chg[0]});
      cyc(1);
      chk("random trip", {15'h0, e}, trip[0]);
      vds0 = 16'sh0;
      clear_cmd = 1'b1;
      cyc(1);
      clear_cmd = 1'b0;
      off_req = 2'h1;
      cyc(1);
      off_req = 2'h0;
    end
    $display("Test random thresholds done");
    ovs = 2'h1;
    uvs = 2'h1;
    cfg(6'h12, 2'h0);
    // Overvoltage holds drive off and refuses new channels until restart ends.
    on_req = 2'h1;
    cyc(5);
    on_req = 2'h0;
    ov = 1'b1;
    cyc(4);
    chk("ov flags", 16'h0007, {ovf, rb, ff});
    chk("drive off", 16'h0000, drv[0]);
    on_req = 2'h2;
    cyc(1);
    on_req = 2'h0;
    cyc(1);
    chk("refused on", 16'h0000, cmd[1]);
    ov = 1'b0;
    cyc(`GDFS_OV_RST1_CYC - 5);
    chk("ov still waiting", 16'h0001, ovf);
    wait_idle(20);
    chk("ov recovered", 16'h0003, {ovf, cmd[0], drv[0]});
    uv = 1'b1;
    cyc(4);
    chk("uv flag", 16'h0001, uvf);
    uv = 1'b0;
    cyc(55);
    chk("uv still waiting", 16'h0001, uvf);
    wait_idle(20);
    chk("uv recovered", 16'h0001, drv[0]);
    clear_cmd = 1'b1;
    luv_clr = 1'b1;
    cyc(1);
    clear_cmd = 1'b0;
    luv_clr = 1'b0;
    cyc(1);
    chk("command clear", 16'h0000, {ff, luvf});
    $display("Test supply done");
    end_sim();
  end
endmodule : testbench
